//--- verilog/rcod_pkg.sv
// Constants and types for the clock-output divider and static configuration block.
// Assumes a single 125 MHz reference clock and a 32-bit Avalon-MM register port.
package rcod_pkg;

    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_VALID = 4'h4;
    localparam logic [3:0] ADDR_STRAP = 4'h8;
    localparam logic [3:0] ADDR_STROBE = 4'hC;

    // Control register fields
    localparam int CTRL_TBSEL_LSB = 0;
    localparam logic [1:0] CTRL_TBSEL_RST = 2'h0;

    // Valid-RAM-and-time status register: flag in the top bit of the byte
    localparam int VALID_FLAG_BIT = 7;

    // Strap and activity status register fields
    localparam int STRAP_DIV_BIT = 0;
    localparam int STRAP_TIMING_BIT = 1;
    localparam int STRAP_ACTIVE_BIT = 2;
    localparam int STRAP_TBSEL_LSB = 4;

    // Strobe event counter register fields
    localparam int STROBE_RD_LSB = 0;
    localparam int STROBE_WR_LSB = 8;

    // Synchronised pin vector positions
    localparam int PIN_TB = 0;
    localparam int PIN_DIVSEL = 1;
    localparam int PIN_TIMING = 2;
    localparam int PIN_PSENSE = 3;
    localparam int PIN_DS = 4;
    localparam int PIN_RW = 5;
    localparam int PIN_CS_N = 6;
    localparam int PIN_COUNT = 7;

    // Reference clock and time-base frequencies in Hz
    localparam int CLK_HZ = 125000000;
    localparam int TB_FAST_HZ = 4194304;
    localparam int TB_MID_HZ = 1048576;
    localparam int TB_SLOW_HZ = 32768;

    // Activity timeout is two time-base periods, rounded up to whole clocks
    localparam int TB_FAST_TIMEOUT_CYC = (2 * CLK_HZ + TB_FAST_HZ - 1) / TB_FAST_HZ;
    localparam int TB_MID_TIMEOUT_CYC = (2 * CLK_HZ + TB_MID_HZ - 1) / TB_MID_HZ;
    localparam int TB_SLOW_TIMEOUT_CYC = (2 * CLK_HZ + TB_SLOW_HZ - 1) / TB_SLOW_HZ;
    localparam int TB_CNT_W = 13;

    // Clocks after reset release before the bus-timing strap is captured
    localparam logic [2:0] STRAP_SETTLE_CYC = 3'h5;

    typedef enum logic [1:0] {
        TBSEL_FAST = 2'b00,
        TBSEL_MID = 2'b01,
        TBSEL_SLOW = 2'b10
    } rcod_tbsel_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } rcod_bus_st_t;

endpackage

//--- verilog/rcod_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
// Assumes asynchronous inputs; the filtered level only moves when stages two and three agree.
`timescale 1ns/1ps
module rcod_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] rise_ff;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] nxt_level;

    // The first stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end else begin
            meta_ff <= pin_i;
            stage2_ff <= meta_ff;
            stage3_ff <= stage2_ff;
        end
    end

    assign agree = ~(stage2_ff ^ stage3_ff);
    assign nxt_level = (agree & stage3_ff) | (~agree & level_ff);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_ff <= '0;
            rise_ff <= '0;
        end else begin
            level_ff <= nxt_level;
            rise_ff <= nxt_level & ~level_ff;
        end
    end

    assign level_o = level_ff;
    assign rise_o = rise_ff;

endmodule // rcod_sync

//--- verilog/rcod_top.sv
// Clock-output divider, strap capture, strobe-style decode and valid-RAM-and-time flag.
// Assumes all pins are asynchronous to ref_clk_i and a single Avalon-MM master.
//
// Functional notes
// - Divide select high: clock output follows the time-base input frequency.
// - Divide select low: clock output runs at one quarter of the time base.
// - Software picks one of three time-base frequencies in a control field.
// - Timing select high: strobe-and-level decode; low: separate read/write pulses.
// - Reading the valid status register sets the valid-RAM-and-time flag.
// - Only power-sense low clears the valid flag; reset keeps the status bit but holds the flag pin low.
// - Valid flag is the top status bit; lower seven bits read zero, unwritable.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module rcod_top #(
    parameter int TB_SLOW_TIMEOUT = rcod_pkg::TB_SLOW_TIMEOUT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic time_base_input_i,
    input wire logic clock_out_divide_select_i,
    input wire logic bus_timing_select_i,
    input wire logic power_sense_input_i,
    input wire logic data_strobe_i,
    input wire logic read_write_i,
    input wire logic chip_select_n_i,
    output logic clock_output_pin_o,
    output logic valid_ram_time_flag_o
);

    logic [rcod_pkg::PIN_COUNT-1:0] pins;
    logic [rcod_pkg::PIN_COUNT-1:0] pin_level;
    logic [rcod_pkg::PIN_COUNT-1:0] pin_rise;
    logic tb_level;
    logic tb_rise;
    logic div_sel;
    logic psense;
    logic ds_level;
    logic rw_level;
    logic cs_active;

    logic [1:0] div_cnt_ff;
    logic clock_out_ff;
    logic [2:0] settle_cnt_ff;
    logic timing_strap_ff;
    logic strap_taken_ff;
    logic ds_prev_ff;
    logic rw_prev_ff;
    logic [7:0] rd_count_ff;
    logic [7:0] wr_count_ff;
    logic [1:0] tbsel_ff;
    logic [rcod_pkg::TB_CNT_W-1:0] tb_idle_cnt_ff;
    logic tb_active_ff;
    logic [rcod_pkg::TB_CNT_W-1:0] tb_timeout;
    logic valid_flag_ff;
    rcod_pkg::rcod_bus_st_t bus_st_ff;
    logic waitreq_ff;
    logic [31:0] rdata_ff;
    logic bus_req;
    logic bus_take;
    logic strobe_rd_evt;
    logic strobe_wr_evt;
    logic valid_read;
    logic power_fail_pin;

    // Power sense crosses inverted: the synchroniser stages reset to zero, so reset and the
    // first clocks after it read as power good and cannot clear the flag on their own.
    assign power_fail_pin = ~power_sense_input_i;
    assign pins = {chip_select_n_i, read_write_i, data_strobe_i, power_fail_pin,
                   bus_timing_select_i, clock_out_divide_select_i, time_base_input_i};

    rcod_sync #(
        .WIDTH(rcod_pkg::PIN_COUNT)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(pins),
        .level_o(pin_level),
        .rise_o(pin_rise)
    );

    assign tb_level = pin_level[rcod_pkg::PIN_TB];
    assign tb_rise = pin_rise[rcod_pkg::PIN_TB];
    assign div_sel = pin_level[rcod_pkg::PIN_DIVSEL];
    assign psense = ~pin_level[rcod_pkg::PIN_PSENSE];
    assign ds_level = pin_level[rcod_pkg::PIN_DS];
    assign rw_level = pin_level[rcod_pkg::PIN_RW];
    assign cs_active = ~pin_level[rcod_pkg::PIN_CS_N];

    // Timeout for the selected time base; an unused encoding is treated as the slowest
    function automatic logic [rcod_pkg::TB_CNT_W-1:0] tb_timeout_for(input logic [1:0] sel);
        case (sel)
            rcod_pkg::TBSEL_FAST: tb_timeout_for = rcod_pkg::TB_CNT_W'(rcod_pkg::TB_FAST_TIMEOUT_CYC);
            rcod_pkg::TBSEL_MID: tb_timeout_for = rcod_pkg::TB_CNT_W'(rcod_pkg::TB_MID_TIMEOUT_CYC);
            default: tb_timeout_for = rcod_pkg::TB_CNT_W'(TB_SLOW_TIMEOUT);
        endcase
    endfunction

    assign tb_timeout = tb_timeout_for(tbsel_ff);

    // Strobe edges, taken from synchronised levels so each edge counts once
    function automatic logic edge_fall(input logic prev, input logic cur);
        edge_fall = prev & ~cur;
    endfunction

    function automatic logic edge_rise(input logic prev, input logic cur);
        edge_rise = ~prev & cur;
    endfunction

    // Register decode shared by the control write and the status read side effect
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
        reg_hit = (addr == reg_addr);
    endfunction

    // Two-bit counter advances on every time-base rising edge; bit one gives 50% duty
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt_ff <= 2'h0;
        end else if (tb_rise) begin
            div_cnt_ff <= div_cnt_ff + 2'h1;
        end
    end

    // Select is followed live; a change mid-period may give one short output phase
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clock_out_ff <= 1'b0;
        end else if (div_sel) begin
            clock_out_ff <= tb_level;
        end else begin
            clock_out_ff <= div_cnt_ff[1];
        end
    end

    // The timing strap is taken once after the synchroniser has settled, then frozen
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_cnt_ff <= 3'h0;
            strap_taken_ff <= 1'b0;
            timing_strap_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            if (settle_cnt_ff == rcod_pkg::STRAP_SETTLE_CYC) begin
                strap_taken_ff <= 1'b1;
                timing_strap_ff <= pin_level[rcod_pkg::PIN_TIMING];
            end else begin
                settle_cnt_ff <= settle_cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ds_prev_ff <= 1'b0;
            rw_prev_ff <= 1'b1;
        end else begin
            ds_prev_ff <= ds_level;
            rw_prev_ff <= rw_level;
        end
    end

    // Strobe-and-level: cycle ends on data strobe fall, direction from the level line.
    // Pulse style: read ends on read-pulse rise, write on write-pulse rise.
    always_comb begin
        strobe_rd_evt = 1'b0;
        strobe_wr_evt = 1'b0;
        if (strap_taken_ff && cs_active) begin
            if (timing_strap_ff) begin
                strobe_rd_evt = edge_fall(ds_prev_ff, ds_level) & rw_level;
                strobe_wr_evt = edge_fall(ds_prev_ff, ds_level) & ~rw_level;
            end else begin
                strobe_rd_evt = edge_rise(ds_prev_ff, ds_level);
                strobe_wr_evt = edge_rise(rw_prev_ff, rw_level);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_count_ff <= 8'h00;
            wr_count_ff <= 8'h00;
        end else begin
            if (strobe_rd_evt) begin
                rd_count_ff <= rd_count_ff + 8'h01;
            end
            if (strobe_wr_evt) begin
                wr_count_ff <= wr_count_ff + 8'h01;
            end
        end
    end

    // Avalon handshake: one wait cycle, then a single cycle with waitrequest low
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_take = bus_req && (bus_st_ff == rcod_pkg::BUS_IDLE);
    assign valid_read = bus_take && avs_read_i && reg_hit(avs_address_i, rcod_pkg::ADDR_VALID);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_st_ff <= rcod_pkg::BUS_IDLE;
            waitreq_ff <= 1'b1;
        end else begin
            case (bus_st_ff)
                rcod_pkg::BUS_IDLE: begin
                    if (bus_req) begin
                        bus_st_ff <= rcod_pkg::BUS_ACK;
                        waitreq_ff <= 1'b0;
                    end
                end
                rcod_pkg::BUS_ACK: begin
                    bus_st_ff <= rcod_pkg::BUS_IDLE;
                    waitreq_ff <= 1'b1;
                end
                default: begin
                    bus_st_ff <= rcod_pkg::BUS_IDLE;
                    waitreq_ff <= 1'b1;
                end
            endcase
        end
    end

    // Time-base selection field; only the low byte lane carries it
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tbsel_ff <= rcod_pkg::CTRL_TBSEL_RST;
        end else if (bus_take && avs_write_i && avs_byteenable_i[0]
                     && reg_hit(avs_address_i, rcod_pkg::ADDR_CTRL)) begin
            tbsel_ff <= avs_writedata_i[rcod_pkg::CTRL_TBSEL_LSB +: 2];
        end
    end

    // Activity monitor scaled by the selected time base
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tb_idle_cnt_ff <= '0;
            tb_active_ff <= 1'b0;
        end else if (tb_rise) begin
            tb_idle_cnt_ff <= '0;
            tb_active_ff <= 1'b1;
        end else if (tb_idle_cnt_ff >= tb_timeout) begin
            tb_active_ff <= 1'b0;
        end else begin
            tb_idle_cnt_ff <= tb_idle_cnt_ff + rcod_pkg::TB_CNT_W'(1);
        end
    end

    // Deliberately no reset: the flag survives reset and only power sense clears it.
    // Power sense low beats a coincident read, so the flag cannot rise while power is bad.
    always_ff @(posedge ref_clk_i) begin
        if (!psense) begin
            valid_flag_ff <= 1'b0;
        end else if (valid_read) begin
            valid_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_take && avs_read_i) begin
            rdata_ff <= 32'h0000_0000;
            case (avs_address_i)
                rcod_pkg::ADDR_CTRL: begin
                    rdata_ff[rcod_pkg::CTRL_TBSEL_LSB +: 2] <= tbsel_ff;
                end
                rcod_pkg::ADDR_VALID: begin
                    rdata_ff[rcod_pkg::VALID_FLAG_BIT] <= valid_flag_ff;
                end
                rcod_pkg::ADDR_STRAP: begin
                    rdata_ff[rcod_pkg::STRAP_DIV_BIT] <= div_sel;
                    rdata_ff[rcod_pkg::STRAP_TIMING_BIT] <= timing_strap_ff;
                    rdata_ff[rcod_pkg::STRAP_ACTIVE_BIT] <= tb_active_ff;
                    rdata_ff[rcod_pkg::STRAP_TBSEL_LSB +: 2] <= tbsel_ff;
                end
                rcod_pkg::ADDR_STROBE: begin
                    rdata_ff[rcod_pkg::STROBE_RD_LSB +: 8] <= rd_count_ff;
                    rdata_ff[rcod_pkg::STROBE_WR_LSB +: 8] <= wr_count_ff;
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Flag output is registered once more so it is driven from reset onward
    logic valid_out_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_out_ff <= 1'b0;
        end else begin
            valid_out_ff <= valid_flag_ff & psense;
        end
    end

    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = waitreq_ff;
    assign clock_output_pin_o = clock_out_ff;
    assign valid_ram_time_flag_o = valid_out_ff;

endmodule // rcod_top

//--- verification/rcod_top_asserts.sv
// Checker for the clock-output divider block, bound to its top module.
// Assumes a steady time base of at least five reference clocks per half period.
`timescale 1ns/1ps
module rcod_top_asserts (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic time_base_input_i,
    input wire logic clock_out_divide_select_i,
    input wire logic bus_timing_select_i,
    input wire logic power_sense_input_i,
    input wire logic clock_output_pin_o,
    input wire logic valid_ram_time_flag_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [3:0] up_ff, ps_ff, hi_ff, lo_ff;
    logic rd_ack;
    assign rd_ack = avs_read_i && !avs_waitrequest_o;
    function automatic logic [3:0] sat(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction
    // Settling counts, because every pin passes several sync stages first
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_ff <= 4'h0;
            ps_ff <= 4'h0;
            hi_ff <= 4'h0;
            lo_ff <= 4'h0;
        end else begin
            up_ff <= sat(up_ff);
            ps_ff <= power_sense_input_i ? sat(ps_ff) : 4'h0;
            hi_ff <= clock_out_divide_select_i ? sat(hi_ff) : 4'h0;
            lo_ff <= clock_out_divide_select_i ? 4'h0 : sat(lo_ff);
        end
    end
    property p_div1;
        hi_ff == 4'hF && $rose(time_base_input_i) |-> ##[3:7] $rose(clock_output_pin_o);
    endproperty
    a_div1: assert property (p_div1) else $error("clock out not following time base");
    property p_div4;
        lo_ff == 4'hF && $changed(clock_output_pin_o) |=> $stable(clock_output_pin_o)[*8];
    endproperty
    a_div4: assert property (p_div4) else $error("divided clock toggles too fast");
    property p_ctrl;
        rd_ack && avs_address_i == rcod_pkg::ADDR_CTRL |-> avs_readdata_o[31:2] == 30'h0;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control read has stray bits");
    property p_strap;
        rd_ack && avs_address_i == rcod_pkg::ADDR_STRAP && up_ff == 4'hF
            |-> avs_readdata_o[rcod_pkg::STRAP_TIMING_BIT] == bus_timing_select_i;
    endproperty
    a_strap: assert property (p_strap) else $error("timing strap readback wrong");
    property p_set_cause;
        $rose(valid_ram_time_flag_o) && up_ff == 4'hF |-> $past(avs_read_i) || $past(avs_read_i, 2);
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("flag rose with no read");
    property p_set;
        rd_ack && avs_address_i == rcod_pkg::ADDR_VALID && ps_ff == 4'hF
            |-> ##[0:2] valid_ram_time_flag_o;
    endproperty
    a_set: assert property (p_set) else $error("flag not set by status read");
    property p_clear;
        !power_sense_input_i [*8] |-> !valid_ram_time_flag_o;
    endproperty
    a_clear: assert property (p_clear) else $error("flag kept while sense low");
    property p_zero;
        rd_ack && avs_address_i == rcod_pkg::ADDR_VALID
            |-> {avs_readdata_o[31:8], avs_readdata_o[6:0]} == 31'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("status low bits not zero");
endmodule // rcod_top_asserts

bind rcod_top rcod_top_asserts rcod_top_asserts_inst (
    .ref_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_readdata_o,
    .avs_waitrequest_o, .time_base_input_i, .clock_out_divide_select_i,
    .bus_timing_select_i, .power_sense_input_i, .clock_output_pin_o, .valid_ram_time_flag_o
);

//--- verification/rcod_host_model.sv
// Host-side model: time-base oscillator, level-style and pulse-style strobe cycles.
// Assumes the device samples these pins with its own reference clock.
`timescale 1ns/1ps
module rcod_host_model #(
    parameter int HALF = 5
) (
    input wire logic ref_clk_i,
    output logic time_base_o,
    output logic data_strobe_o,
    output logic read_write_o,
    output logic chip_select_n_o
);
    initial begin
        time_base_o = 1'b0;
        data_strobe_o = 1'b0;
        read_write_o = 1'b1;
        chip_select_n_o = 1'b1;
        forever begin
            repeat (HALF) @(posedge ref_clk_i);
            time_base_o <= ~time_base_o;
        end
    end
    // Select and direction settle before the strobe and outlast it
    task automatic strobe_cycle(input logic rd, input logic cs_n);
        @(posedge ref_clk_i);
        chip_select_n_o <= cs_n;
        read_write_o <= rd;
        repeat (4) @(posedge ref_clk_i);
        data_strobe_o <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        data_strobe_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        chip_select_n_o <= 1'b1;
        read_write_o <= 1'b1;
    endtask
    // Pulse style: the read or write line pulses low inside a low select; strobe idles high
    task automatic pulse_cycle(input logic rd);
        @(posedge ref_clk_i);
        data_strobe_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chip_select_n_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        if (rd) begin
            data_strobe_o <= 1'b0;
        end else begin
            read_write_o <= 1'b0;
        end
        repeat (8) @(posedge ref_clk_i);
        data_strobe_o <= 1'b1;
        read_write_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chip_select_n_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        data_strobe_o <= 1'b0;
    endtask
endmodule // rcod_host_model

//--- verification/rcod_top_test.sv
// Self-checking bench for the clock-output divider block.
// Assumes the host model supplies time base and strobes; registers via Avalon-MM.
`timescale 1ns/1ps
module rcod_top_test;
    localparam int TBH = 5;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic divsel = 1'b1;
    logic timing_sel = 1'b1;
    logic psense = 1'b0;
    logic tbase, ds, rw, cs_n, clock_output_pin, vflag;
    logic [31:0] rd;
    int fails = 0;
    int checked = 0;
    int per, hi;
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    rcod_host_model #(.HALF(TBH)) rcod_host_model_inst (
        .ref_clk_i(ref_clk_i), .time_base_o(tbase), .data_strobe_o(ds),
        .read_write_o(rw), .chip_select_n_o(cs_n)
    );
    rcod_top #(.TB_SLOW_TIMEOUT(100)) rcod_top_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .time_base_input_i(tbase),
        .clock_out_divide_select_i(divsel),
        .bus_timing_select_i(timing_sel),
        .power_sense_input_i(psense), .data_strobe_i(ds), .read_write_i(rw),
        .chip_select_n_i(cs_n), .clock_output_pin_o(clock_output_pin), .valid_ram_time_flag_o(vflag)
    );
    task automatic end_sim();
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 50) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Counts clocks while the output holds one level; bounded against a stuck pin
    task automatic span(input logic v, output int c);
        c = 0;
        while (clock_output_pin === v && c < 100) begin
            @(posedge ref_clk_i);
            c++;
        end
        if (c >= 100) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic meas();
        span(1'b1, hi);
        span(1'b0, per);
        span(1'b1, hi);
        span(1'b0, per);
        per = per + hi;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        psense <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rd_chk(rcod_pkg::ADDR_VALID, 32'h0);
        rd_chk(rcod_pkg::ADDR_VALID, 32'h80);
        bus_xfer(1'b1, rcod_pkg::ADDR_VALID, 32'hFFFF_FFFF);
        rd_chk(rcod_pkg::ADDR_VALID, 32'h80);
        reset_n_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk(vflag, 32'h1);
        rd_chk(rcod_pkg::ADDR_VALID, 32'h80);
        psense <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk(vflag, 32'h0);
        psense <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rd_chk(rcod_pkg::ADDR_VALID, 32'h0);
        rd_chk(rcod_pkg::ADDR_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            bus_xfer(1'b1, rcod_pkg::ADDR_CTRL, 32'(i));
            rd_chk(rcod_pkg::ADDR_CTRL, 32'(i));
        end
        rd_chk(4'h2, 32'h0);
        rd_chk(rcod_pkg::ADDR_STRAP, 32'h27);
        rcod_host_model_inst.strobe_cycle(1'b1, 1'b0);
        rcod_host_model_inst.strobe_cycle(1'b0, 1'b0);
        rcod_host_model_inst.strobe_cycle(1'b1, 1'b1);
        repeat (8) @(posedge ref_clk_i);
        rd_chk(rcod_pkg::ADDR_STROBE, 32'h0101);
        meas();
        chk(hi, TBH);
        chk(per, 2 * TBH);
        divsel <= 1'b0;
        repeat (40) @(posedge ref_clk_i);
        meas();
        chk(hi, 4 * TBH);
        chk(per, 8 * TBH);
        // The strap moves only while reset holds the block, as a board tie would at power-up
        reset_n_i <= 1'b0;
        timing_sel <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        rd_chk(rcod_pkg::ADDR_STRAP, 32'h04);
        rcod_host_model_inst.pulse_cycle(1'b1);
        rcod_host_model_inst.pulse_cycle(1'b0);
        repeat (8) @(posedge ref_clk_i);
        rd_chk(rcod_pkg::ADDR_STROBE, 32'h0101);
        end_sim();
    end
endmodule // rcod_top_test
